// ### pkg/csm_pkg.sv
// Package of constants, types and register map for the speed reference block
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package csm_pkg;

  // Register byte offsets
  localparam logic [11:0] CSM_OFF_CTRL = 12'h000;
  localparam logic [11:0] CSM_OFF_SRC = 12'h004;
  localparam logic [11:0] CSM_OFF_REFA = 12'h008;
  localparam logic [11:0] CSM_OFF_REFB = 12'h00C;
  localparam logic [11:0] CSM_OFF_RATE = 12'h010;
  localparam logic [11:0] CSM_OFF_FMAX = 12'h014;
  localparam logic [11:0] CSM_OFF_STAT = 12'h018;
  localparam logic [11:0] CSM_OFF_OUT = 12'h01C;
  localparam logic [11:0] CSM_OFF_MOT = 12'h020;
  localparam logic [11:0] CSM_OFF_PRE1 = 12'h040;
  localparam logic [11:0] CSM_OFF_PRE7 = 12'h058;

  // Widths
  localparam int CSM_FW = 16;
  localparam int CSM_NPRE = 7;
  localparam int CSM_NDI = 6;

  // Reference source codes
  localparam logic [7:0] CSM_SRC_MOTOR = 8'h8A;
  localparam logic [2:0] CSM_DI_OFF = 3'h0;

  // Reset values
  localparam logic [15:0] CSM_RATE_RST = 16'h0001;
  localparam logic [15:0] CSM_FMAX_RST = 16'h1388;
  localparam logic [15:0] CSM_ZERO_F = 16'h0000;
  localparam logic [31:0] CSM_BAD_ADDR = 32'h0000_0000;

  // Motorized retention modes
  typedef enum logic [1:0] {
    CSM_MODE_CLEAR,
    CSM_MODE_KEEP_LOCK,
    CSM_MODE_TRACK,
    CSM_MODE_KEEP_FREE
  } csm_mode_t;

  // Source selections, one 3-bit code per signal
  typedef struct packed {
    logic [2:0] decrease;
    logic [2:0] increase;
    logic [2:0] sel2;
    logic [2:0] sel1;
    logic [2:0] sel0;
  } csm_src_t;

  // Per-place reference settings
  typedef struct packed {
    logic [7:0] ref_code;
    logic [15:0] ext_ref;
  } csm_place_t;

endpackage : csm_pkg

// ### rtl/csm_motor_ref.sv
// Motorized reference accumulator with four retention modes
`timescale 1ns/10ps
module csm_motor_ref
  import csm_pkg::*;
#(
  parameter int FW = CSM_FW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic up_cmd,
  input wire logic down_cmd,
  input wire logic running,
  input wire logic motor_active,
  input wire csm_mode_t mode,
  input wire logic [FW-1:0] active_ref,
  input wire logic [FW-1:0] rate,
  input wire logic [FW-1:0] fmax,
  output logic [FW-1:0] value
);

  logic [FW-1:0] value_ff; // Accumulated reference
  logic [FW-1:0] nxt_value;
  logic [FW:0] sum; // One extra bit catches overflow
  logic allow; // Commands accepted this cycle

  // Next value of the accumulator
  always_comb begin
    sum = {1'b0, value_ff} + {1'b0, rate};
    allow = running || (mode == CSM_MODE_KEEP_FREE);
    nxt_value = value_ff;
    if (mode == CSM_MODE_TRACK && !motor_active) begin
      nxt_value = active_ref;
    end else if (mode == CSM_MODE_CLEAR && !running) begin
      nxt_value = CSM_ZERO_F;
    end else if (allow && up_cmd && !down_cmd) begin
      // Saturate at the ceiling rather than wrap
      if (sum > {1'b0, fmax}) begin
        nxt_value = fmax;
      end else begin
        nxt_value = sum[FW-1:0];
      end
    end else if (allow && down_cmd && !up_cmd) begin
      if (value_ff < rate) begin
        nxt_value = CSM_ZERO_F;
      end else begin
        nxt_value = value_ff - rate;
      end
    end
    // Both commands: hold, as initialised above
  end

  // Accumulator register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= CSM_ZERO_F;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;

  // Checks
  hold_both_a: assert property (@(posedge pclk) disable iff (!presetn)
    up_cmd && down_cmd && mode != CSM_MODE_TRACK && running
    |=> value_ff == $past(value_ff))
    else $error("Motor value moved with both commands");
  clear_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == CSM_MODE_CLEAR && !running |=> value_ff == CSM_ZERO_F)
    else $error("Mode 0 stop did not clear");
  lock_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == CSM_MODE_KEEP_LOCK && !running |=> value_ff == $past(value_ff))
    else $error("Mode 1 changed while stopped");
  free_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == CSM_MODE_KEEP_FREE && up_cmd && !down_cmd
    |=> value_ff >= $past(value_ff))
    else $error("Mode 3 increase went down");
  track_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == CSM_MODE_TRACK && !motor_active |=> value_ff == $past(active_ref))
    else $error("Mode 2 not tracking");
  ceiling_a: assert property (@(posedge pclk) disable iff (!presetn)
    up_cmd && !$stable(value_ff) && mode != CSM_MODE_TRACK
    |-> value_ff <= $past(fmax))
    else $error("Motor value above ceiling");
  ramp_c: cover property (@(posedge pclk) disable iff (!presetn)
    up_cmd [*3] ##1 down_cmd);

endmodule : csm_motor_ref

// ### rtl/csm_speed_ref.sv
// Preset and motorized frequency reference selector with APB registers
`timescale 1ns/10ps
module csm_speed_ref
  import csm_pkg::*;
#(
  parameter int FW = CSM_FW,
  parameter int NPRE = CSM_NPRE,
  parameter int NDI = CSM_NDI
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NDI-1:0] digital_in,
  input wire logic running,
  output logic [FW-1:0] freq_ref,
  output logic fixed_frequency_indicator,
  output logic motor_ref_active
);

  //////////////////////////////////////////////////////////////////////////
  // Register storage
  logic place_b_ff; // Control place select
  logic [1:0] mode_ff; // Retention mode
  csm_src_t src_ff; // Input source codes
  csm_place_t place_a_ff; // Place A reference settings
  csm_place_t place_b_cfg_ff; // Place B reference settings
  logic [FW-1:0] rate_ff; // Ramp step per clock
  logic [FW-1:0] fmax_ff; // Ramp ceiling
  logic [FW-1:0] preset_ff [NPRE]; // Stored presets
  logic nxt_place_b;
  logic [1:0] nxt_mode;
  csm_src_t nxt_src;
  csm_place_t nxt_place_a;
  csm_place_t nxt_place_b_cfg;
  logic [FW-1:0] nxt_rate;
  logic [FW-1:0] nxt_fmax;
  logic [FW-1:0] nxt_preset [NPRE];

  // Output registers
  logic [FW-1:0] freq_ff;
  logic fixed_ff;
  logic motor_ff;
  logic [FW-1:0] nxt_freq;
  logic nxt_fixed;
  logic nxt_motor;

  // Bus decode helpers
  logic wr_en;
  logic rd_hit;
  logic [31:0] rd_data;
  int pidx; // Preset slot index

  // Routed signals
  logic [2:0] preset_code;
  logic up_cmd;
  logic down_cmd;
  csm_place_t place_sel;
  logic [FW-1:0] motor_val;
  csm_mode_t mode_e;

  //////////////////////////////////////////////////////////////////////////
  // Input routing: code zero and codes above NDI force low, code n from 1 to NDI picks input n
  function automatic logic route_di(input logic [2:0] code,
                                    input logic [NDI-1:0] di);
    logic bit_v;
    bit_v = 1'b0;
    if (code != CSM_DI_OFF && int'(code) <= NDI) begin
      bit_v = di[int'(code) - 1];
    end
    return bit_v;
  endfunction : route_di

  always_comb begin
    preset_code = {route_di(src_ff.sel2, digital_in),
                   route_di(src_ff.sel1, digital_in),
                   route_di(src_ff.sel0, digital_in)};
    up_cmd = route_di(src_ff.increase, digital_in);
    down_cmd = route_di(src_ff.decrease, digital_in);
    place_sel = place_b_ff ? place_b_cfg_ff : place_a_ff;
    mode_e = csm_mode_t'(mode_ff);
  end

  //////////////////////////////////////////////////////////////////////////
  // Motorized reference
  csm_motor_ref #(
    .FW(FW)
  ) csm_motor_ref_i (
    .pclk(pclk),
    .presetn(presetn),
    .up_cmd(up_cmd),
    .down_cmd(down_cmd),
    .running(running),
    .motor_active(place_sel.ref_code == CSM_SRC_MOTOR),
    .mode(mode_e),
    .active_ref(place_sel.ext_ref),
    .rate(rate_ff),
    .fmax(fmax_ff),
    .value(motor_val)
  );

  //////////////////////////////////////////////////////////////////////////
  // Reference selection: presets override every other source
  always_comb begin
    nxt_fixed = (preset_code != 3'h0);
    nxt_motor = !nxt_fixed && (place_sel.ref_code == CSM_SRC_MOTOR);
    if (nxt_fixed) begin
      nxt_freq = preset_ff[int'(preset_code) - 1];
    end else if (nxt_motor) begin
      nxt_freq = motor_val;
    end else begin
      nxt_freq = place_sel.ext_ref;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_ff <= CSM_ZERO_F;
      fixed_ff <= 1'b0;
      motor_ff <= 1'b0;
    end else begin
      freq_ff <= nxt_freq;
      fixed_ff <= nxt_fixed;
      motor_ff <= nxt_motor;
    end
  end

  assign freq_ref = freq_ff;
  assign fixed_frequency_indicator = fixed_ff;
  assign motor_ref_active = motor_ff;

  //////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign pidx = int'((paddr - CSM_OFF_PRE1) >> 2);

  // Read mux and address hit
  always_comb begin
    rd_hit = 1'b1;
    rd_data = CSM_BAD_ADDR;
    unique case (paddr)
      CSM_OFF_CTRL: rd_data = {29'h0, mode_ff, place_b_ff};
      CSM_OFF_SRC: rd_data = {17'h0, src_ff};
      CSM_OFF_REFA: rd_data = {8'h0, place_a_ff};
      CSM_OFF_REFB: rd_data = {8'h0, place_b_cfg_ff};
      CSM_OFF_RATE: rd_data = {16'h0, rate_ff};
      CSM_OFF_FMAX: rd_data = {16'h0, fmax_ff};
      CSM_OFF_STAT: rd_data = {26'h0, preset_code, running,
                               motor_ff, fixed_ff};
      CSM_OFF_OUT: rd_data = {16'h0, freq_ff};
      CSM_OFF_MOT: rd_data = {16'h0, motor_val};
      default: begin
        // Presets sit on consecutive words
        if (paddr >= CSM_OFF_PRE1 && paddr <= CSM_OFF_PRE7
            && paddr[1:0] == 2'h0) begin
          rd_data = {16'h0, preset_ff[pidx]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= CSM_BAD_ADDR;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_data; // Captured in setup, stable for access
    end
  end

  // Register writes
  always_comb begin
    nxt_place_b = place_b_ff;
    nxt_mode = mode_ff;
    nxt_src = src_ff;
    nxt_place_a = place_a_ff;
    nxt_place_b_cfg = place_b_cfg_ff;
    nxt_rate = rate_ff;
    nxt_fmax = fmax_ff;
    nxt_preset = preset_ff;
    if (wr_en && rd_hit) begin
      unique case (paddr)
        CSM_OFF_CTRL: begin
          nxt_place_b = pwdata[0];
          nxt_mode = pwdata[2:1];
        end
        CSM_OFF_SRC: nxt_src = csm_src_t'(pwdata[14:0]);
        CSM_OFF_REFA: nxt_place_a = csm_place_t'(pwdata[23:0]);
        CSM_OFF_REFB: nxt_place_b_cfg = csm_place_t'(pwdata[23:0]);
        CSM_OFF_RATE: nxt_rate = pwdata[FW-1:0];
        CSM_OFF_FMAX: nxt_fmax = pwdata[FW-1:0];
        default: begin
          if (paddr >= CSM_OFF_PRE1) begin
            nxt_preset[pidx] = pwdata[FW-1:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      place_b_ff <= 1'b0;
      mode_ff <= 2'h0;
      src_ff <= '0;
      place_a_ff <= '0;
      place_b_cfg_ff <= '0;
      rate_ff <= CSM_RATE_RST;
      fmax_ff <= CSM_FMAX_RST;
      for (int i = 0; i < NPRE; i++) begin
        preset_ff[i] <= CSM_ZERO_F;
      end
    end else begin
      place_b_ff <= nxt_place_b;
      mode_ff <= nxt_mode;
      src_ff <= nxt_src;
      place_a_ff <= nxt_place_a;
      place_b_cfg_ff <= nxt_place_b_cfg;
      rate_ff <= nxt_rate;
      fmax_ff <= nxt_fmax;
      preset_ff <= nxt_preset;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  preset_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
    preset_code != 3'h0 |=> freq_ff == $past(preset_ff[int'(preset_code) - 1]))
    else $error("Preset frequency not selected");
  preset_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    preset_code == 3'h0 |=> !fixed_ff)
    else $error("Preset flag with zero code");
  motor_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    preset_code == 3'h0 && place_sel.ref_code == CSM_SRC_MOTOR
    |=> motor_ff && freq_ff == $past(motor_val))
    else $error("Motor reference not routed");
  off_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_ff.sel0 == CSM_DI_OFF && src_ff.sel1 == CSM_DI_OFF
    && src_ff.sel2 == CSM_DI_OFF |-> !nxt_fixed)
    else $error("Disabled sources selected a preset");
  place_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
    place_b_ff && preset_code == 3'h0 && place_b_cfg_ff.ref_code
    != CSM_SRC_MOTOR |=> freq_ff == $past(place_b_cfg_ff.ext_ref))
    else $error("Place B not applied");
  preset_c: cover property (@(posedge pclk) disable iff (!presetn)
    fixed_ff ##1 !fixed_ff);
  motor_c: cover property (@(posedge pclk) disable iff (!presetn)
    motor_ff && up_cmd);
  place_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(place_b_ff));

endmodule : csm_speed_ref

// ### verif/csm_operator.sv
// Operator switch bank model driving the drive's digital inputs
`timescale 1ns/10ps
module csm_operator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] contacts, // Switch positions chosen by the bench
  output logic [5:0] digital_in // Input n at bit n-1
);
  // Contacts are sampled on the clock so they never move mid-cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digital_in <= 6'h00;
    end else begin
      digital_in <= contacts;
    end
  end
endmodule : csm_operator

// ### verif/csm_speed_ref_tb.sv
// Self-checking bench for the speed reference selector
`timescale 1ns/10ps
module csm_speed_ref_tb import csm_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] contacts, digital_in;
  logic running, fixed_frequency_indicator, motor_ref_active;
  logic [15:0] freq_ref;
  int fails, comparisons;
  //////////////////////////////////////////////////////////////////////
  csm_speed_ref csm_speed_ref_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digital_in(digital_in), .running(running),
    .freq_ref(freq_ref),
    .fixed_frequency_indicator(fixed_frequency_indicator),
    .motor_ref_active(motor_ref_active));
  csm_operator csm_operator_i (.pclk(pclk), .presetn(presetn),
    .contacts(contacts), .digital_in(digital_in));
  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Counts: %0d compared, %0d mismatched", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer; entered just after a rising edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("[ERR] pready expected 1 seen %b", pready);
      end_of_test();
    end else begin
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdchk
  // Bounded wait for the reference output to reach a value
  task automatic wait_ref(logic [15:0] exp);
    int n;
    n = 0;
    while (freq_ref !== exp && n < 200) begin
      @(posedge pclk);
      n++;
    end
    // A used-up bound shows here as a mismatch, then the run ends
    check("freq_ref", 32'(freq_ref), 32'(exp));
    if (n >= 200) begin
      end_of_test();
    end
  endtask : wait_ref
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("ctrl", CSM_OFF_CTRL, 32'h0);
    rdchk("rate", CSM_OFF_RATE, 32'(CSM_RATE_RST));
    rdchk("fmax", CSM_OFF_FMAX, 32'(CSM_FMAX_RST));
    rdchk("pre1", CSM_OFF_PRE1, 32'h0);
    apb(1'b1, 12'h0FC, 32'h1234);
    check("slverr", 32'(perr), 32'h1);
    rdchk("hole", 12'h0FC, 32'h0);
    $display("test reset done");
  endtask : t_reset
  // Three selectors on inputs 5, 6 and 3; every code visited
  task automatic t_presets;
    logic [15:0] exp;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, CSM_OFF_PRE1 + 12'(4 * i), 32'(16'h0100 * (i + 1) + 16'h11));
    end
    apb(1'b1, CSM_OFF_SRC, 32'h22F5);
    apb(1'b1, CSM_OFF_REFA, 32'h0055);
    for (int k = 0; k < 8; k++) begin
      contacts <= {k[1], k[0], 1'b0, k[2], 2'b00};
      exp = (k == 0) ? 16'h0055 : 16'(16'h0100 * k + 16'h11);
      wait_ref(exp);
      check("fixed", 32'(fixed_frequency_indicator), 32'(k != 0));
    end
    // Second selector forced off: code 3 drops to 1
    apb(1'b1, CSM_OFF_SRC, 32'h22C5);
    contacts <= 6'h30;
    wait_ref(16'h0111);
    // Place B carries its own reference
    apb(1'b1, CSM_OFF_REFB, 32'h0066);
    apb(1'b1, CSM_OFF_CTRL, 32'h1);
    contacts <= 6'h00;
    wait_ref(16'h0066);
    apb(1'b1, CSM_OFF_CTRL, 32'h0);
    $display("test presets done");
  endtask : t_presets
  // Increase on input 1, decrease on input 2
  task automatic t_motor;
    apb(1'b1, CSM_OFF_SRC, 32'h22F5);
    apb(1'b1, CSM_OFF_RATE, 32'h0100);
    apb(1'b1, CSM_OFF_FMAX, 32'h0400);
    apb(1'b1, CSM_OFF_REFA, 32'h008A0055);
    apb(1'b1, CSM_OFF_CTRL, 32'h6);
    running <= 1'b1;
    wait_ref(16'h0000);
    check("motor", 32'(motor_ref_active), 32'h1);
    contacts <= 6'h01;
    wait_ref(16'h0400);
    // Both held before the ceiling rises, so a wrong winner would move
    // the value while increase alone has already stopped
    contacts <= 6'h03;
    apb(1'b1, CSM_OFF_FMAX, 32'h0800);
    repeat (12) @(posedge pclk);
    rdchk("both", CSM_OFF_MOT, 32'h0400);
    contacts <= 6'h02;
    wait_ref(16'h0000);
    contacts <= 6'h01;
    wait_ref(16'h0800);
    contacts <= 6'h00;
    $display("test motor done");
  endtask : t_motor
  task automatic t_modes;
    apb(1'b1, CSM_OFF_CTRL, 32'h2);
    running <= 1'b0;
    contacts <= 6'h02;
    repeat (20) @(posedge pclk);
    rdchk("lock", CSM_OFF_MOT, 32'h0800);
    contacts <= 6'h00;
    apb(1'b1, CSM_OFF_CTRL, 32'h0);
    wait_ref(16'h0000);
    // Mode 3 off the motorized source, still stopped
    apb(1'b1, CSM_OFF_CTRL, 32'h6);
    apb(1'b1, CSM_OFF_REFA, 32'h0055);
    contacts <= 6'h01;
    repeat (20) @(posedge pclk);
    // Twenty cycles of increase run the value up to the ceiling
    rdchk("free", CSM_OFF_MOT, 32'h0800);
    wait_ref(16'h0055);
    check("motor", 32'(motor_ref_active), 32'h0);
    contacts <= 6'h00;
    apb(1'b1, CSM_OFF_REFA, 32'h0123);
    apb(1'b1, CSM_OFF_CTRL, 32'h4);
    running <= 1'b1;
    repeat (6) @(posedge pclk);
    rdchk("track", CSM_OFF_MOT, 32'h0123);
    apb(1'b1, CSM_OFF_REFA, 32'h008A0123);
    wait_ref(16'h0123);
    // Flags settle one edge after the write; the value must not bump
    repeat (2) @(posedge pclk);
    check("bumpless", 32'(freq_ref), 32'h0123);
    check("motor", 32'(motor_ref_active), 32'h1);
    $display("test modes done");
  endtask : t_modes
  //////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    contacts = 6'h00;
    running = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_presets();
    t_motor();
    t_modes();
    end_of_test();
  end
endmodule : csm_speed_ref_tb
